// ### core/gpio_port_consts.svh
/*
  Constants for the bidirectional port block: widths and reset values.
  Assumes inclusion by the package and by the design modules.
*/
`ifndef GPIO_PORT_CONSTS_SVH
`define GPIO_PORT_CONSTS_SVH
// =====================================================================
// Geometry
`define PORT_WIDTH      8
`define PORT_COUNT      13
`define PORT_SEL_W      4
// =====================================================================
// Reset values
`define DIR_RESET       8'h00
`define LATCH_RESET     8'h00
`endif

// ### core/gpio_port_pkg.sv
/*
  Types shared by the port modules.
  Assumes the constants header sits in the include path.
*/
`include "gpio_port_consts.svh"
package gpio_port_pkg;
  // =====================================================================
  // Types
  typedef logic [`PORT_WIDTH-1:0]  port_word_t;
  typedef logic [`PORT_SEL_W-1:0]  port_sel_t;
endpackage

// ### core/port_reg_bank.sv
/*
  Small register bank holding one word per port, registered read port.
  Assumes one writer and one reader on the same clock.
*/
`timescale 1ns/1ns
`include "gpio_port_consts.svh"
module port_reg_bank #(
  parameter int WIDTH = `PORT_WIDTH,
  parameter int DEPTH = `PORT_COUNT,
  parameter int SEL_W = `PORT_SEL_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Write side
  input  wire logic             wr_en,
  input  wire logic [SEL_W-1:0] wr_sel,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read side
  input  wire logic [SEL_W-1:0] rd_sel,
  output logic      [WIDTH-1:0] rd_data,
  // Whole contents, for pin drive
  output logic      [WIDTH*DEPTH-1:0] all_data
);
  // =====================================================================
  // Storage
  logic [WIDTH-1:0] mem      [DEPTH];  // Stored words
  logic [WIDTH-1:0] next_mem [DEPTH];  // Their next values
  logic [WIDTH-1:0] next_rd;           // Next read word

  // Next values: write one entry, pick the read word
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = (wr_en && wr_sel == SEL_W'(i)) ? wr_data : mem[i];
    end
    next_rd = '0;
    // Out-of-range select reads as zero
    if (rd_sel < SEL_W'(DEPTH)) begin
      next_rd = mem[rd_sel];
    end
  end

  // Register storage and read data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      mem     <= next_mem;
      rd_data <= next_rd;
    end
  end

  // Flatten contents for continuous use
  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_flat
      assign all_data[g*WIDTH +: WIDTH] = mem[g];
    end
  endgenerate
endmodule // port_reg_bank

// ### core/bidirectional_port_pins.sv
/*
  Bidirectional general-purpose ports: per-pin direction, data latches,
  pin drive and readback. Assumes the processor side is synchronous to
  clk and that pin inputs are asynchronous.
*/
`timescale 1ns/1ns
`include "gpio_port_consts.svh"
module bidirectional_port_pins #(
  parameter int WIDTH = `PORT_WIDTH,
  parameter int PORTS = `PORT_COUNT
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  // Processor access
  input  wire logic                    wr_en,
  input  wire logic                    wr_dir,
  input  wire gpio_port_pkg::port_sel_t port_sel,
  input  wire gpio_port_pkg::port_word_t wr_data,
  input  wire logic                    rd_en,
  output gpio_port_pkg::port_word_t    rd_data,
  output gpio_port_pkg::port_word_t    rd_dir,
  output logic                         rd_valid,
  // Pins
  input  wire logic [WIDTH*PORTS-1:0]  pin_in,
  output logic      [WIDTH*PORTS-1:0]  pin_out,
  output logic      [WIDTH*PORTS-1:0]  pin_oe_n
);
  import gpio_port_pkg::*;

  // =====================================================================
  // Direction registers and pin synchroniser
  logic [WIDTH*PORTS-1:0] dir;        // 1 = output
  logic [WIDTH*PORTS-1:0] next_dir;
  logic [WIDTH*PORTS-1:0] pin_meta;   // First stage, read only by pin_sync
  logic [WIDTH*PORTS-1:0] pin_sync;   // Safe pin levels
  logic [WIDTH*PORTS-1:0] latch_all;  // Latch contents from bank
  logic [WIDTH*PORTS-1:0] next_oe_n;
  logic [WIDTH*PORTS-1:0] next_out;
  port_word_t             latch_rd;   // Registered latch read
  port_word_t             next_rd;
  port_word_t             next_rdir;
  logic                   rd_pend;    // Read issued last cycle
  port_sel_t              rd_sel_q;   // Its port

  // Next direction: a direction write touches one port only
  always_comb begin
    next_dir = dir;
    for (int p = 0; p < PORTS; p++) begin
      if (wr_en && wr_dir && port_sel == port_sel_t'(p)) begin
        next_dir[p*WIDTH +: WIDTH] = wr_data;
      end
    end
  end

  // Register direction and two-stage pin sampling
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir      <= '0;             // All pins float at reset
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      dir      <= next_dir;
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end

  // =====================================================================
  // Data latches: written regardless of direction
  port_reg_bank #(
    .WIDTH (WIDTH),
    .DEPTH (PORTS),
    .SEL_W (`PORT_SEL_W)
  ) u_latch (
    .clk      (clk),
    .rst_n    (rst_n),
    .wr_en    (wr_en && !wr_dir),  // Latch write ignores direction
    .wr_sel   (port_sel),
    .wr_data  (wr_data),
    .rd_sel   (port_sel),
    .rd_data  (latch_rd),
    .all_data (latch_all)
  );

  // =====================================================================
  // Pin drive and readback
  always_comb begin
    // Enable low while driving; direction 1 drives the latch
    next_oe_n = ~next_dir;
    next_out  = next_dir & latch_all;
    next_rd   = '0;
    next_rdir = '0;
    for (int p = 0; p < PORTS; p++) begin
      if (rd_sel_q == port_sel_t'(p)) begin
        // Per bit: latch for outputs, pin for inputs
        next_rd = (dir[p*WIDTH +: WIDTH] & latch_rd)
                | (~dir[p*WIDTH +: WIDTH] & pin_sync[p*WIDTH +: WIDTH]);
        next_rdir = dir[p*WIDTH +: WIDTH];
      end
    end
  end

  // Register outputs; read answers two cycles after request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= '1;
      pin_out  <= '0;
      rd_pend  <= 1'b0;
      rd_sel_q <= '0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
      rd_dir   <= '0;
    end else begin
      pin_oe_n <= next_oe_n;
      pin_out  <= next_out;
      rd_pend  <= rd_en;
      rd_sel_q <= port_sel;
      rd_valid <= rd_pend;
      rd_data  <= rd_pend ? next_rd : rd_data;
      rd_dir   <= rd_pend ? next_rdir : rd_dir;
    end
  end

  // =====================================================================
  // Checks
  // Enables come from the next direction, so they track dir exactly
  property p_float_on_input;
    @(posedge clk) disable iff (!rst_n)
      pin_oe_n == ~dir;
  endproperty
  a_float_on_input: assert property (p_float_on_input)
    else $error("pin enable does not follow direction");

  // A floating pin carries no stale drive value
  property p_float_no_drive;
    @(posedge clk) disable iff (!rst_n)
      (pin_out & pin_oe_n) == '0;
  endproperty
  a_float_no_drive: assert property (p_float_no_drive)
    else $error("floating pin carries a drive value");

  // Driven bits show the latch one cycle after it settles

  property p_drive_latch;
    @(posedge clk) disable iff (!rst_n)
      ##1 ((pin_out & ~pin_oe_n) == ($past(latch_all) & ~pin_oe_n));
  endproperty
  a_drive_latch: assert property (p_drive_latch)
    else $error("driven pin differs from latch");

  // Any fully driven port reads back its latch, whatever loads the pins
  property p_readback_out;
    @(posedge clk) disable iff (!rst_n)
      rd_pend && rd_sel_q < PORTS && (&dir[rd_sel_q*WIDTH +: WIDTH])
      |=> (rd_valid && rd_data == $past(latch_rd));
  endproperty
  a_readback_out: assert property (p_readback_out)
    else $error("output readback not from latch");

  // A floating port 0 reads back its synchronised pin levels
  property p_readback_in;
    @(posedge clk) disable iff (!rst_n)
      rd_pend && dir[WIDTH-1:0] == '0 && rd_sel_q == '0
      |=> (rd_data == $past(pin_sync[WIDTH-1:0]));
  endproperty
  a_readback_in: assert property (p_readback_in)
    else $error("input readback not from pin");

  // A latch write never moves a pin enable, so inputs stay floating
  property p_write_input_float;
    @(posedge clk) disable iff (!rst_n)
      wr_en && !wr_dir |=> pin_oe_n == $past(pin_oe_n);
  endproperty
  a_write_input_float: assert property (p_write_input_float)
    else $error("latch write drove an input pin");

  property p_dir_write;
    @(posedge clk) disable iff (!rst_n)
      wr_en && wr_dir && port_sel == '0 |=> dir[WIDTH-1:0] == $past(wr_data);
  endproperty
  a_dir_write: assert property (p_dir_write)
    else $error("direction write not stored");

  // Direction only changes through a direction write
  property p_dir_hold;
    @(posedge clk) disable iff (!rst_n)
      !(wr_en && wr_dir) |=> dir == $past(dir);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a direction write");

  property p_reset_float;
    @(posedge clk) $rose(rst_n) |-> (dir == '0 && pin_oe_n == '1);
  endproperty
  a_reset_float: assert property (p_reset_float)
    else $error("pins not floating after reset");

  property p_read_timing;
    @(posedge clk) disable iff (!rst_n)
      rd_en |=> ##1 rd_valid;
  endproperty
  a_read_timing: assert property (p_read_timing)
    else $error("read answer late");

  // Read results stand until the next answer
  property p_read_hold;
    @(posedge clk) disable iff (!rst_n)
      !rd_pend |=> (!rd_valid && $stable(rd_data) && $stable(rd_dir));
  endproperty
  a_read_hold: assert property (p_read_hold)
    else $error("read result changed without a read");
endmodule // bidirectional_port_pins

// ### tb/pin_load_model.sv
/*
  External circuitry on the port pins: optional strong drive per pin,
  otherwise the device drive, otherwise a drifting floating level.
  Assumes active-low pin enables and the bench clock.
*/
`timescale 1ns/1ns
// =====================================================================
// Pin load model
module pin_load_model #(
  parameter int N = 104
) (
  // Clock
  input  wire logic         clk,
  // Device side
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe_n,
  // External drive, from the bench
  input  wire logic [N-1:0] ext_val,
  input  wire logic [N-1:0] ext_en,
  // Wire level seen by the device
  output logic      [N-1:0] pin_in
);
  // Floating lines flip each cycle, so a stale value never passes
  logic [N-1:0] drift = '0;
  always @(posedge clk) drift <= ~drift;
  // Strong load beats the device driver, which makes readback telling
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
      else pin_in[i] = drift[i];
    end
  end
endmodule // pin_load_model

// ### tb/bidirectional_port_pins_bench.sv
/*
  Self-checking bench for the port block: reset state, direction bits,
  input reads, latch writes while floating, output drive and readback.
  Assumes the pin load model drives pin_in.
*/
`timescale 1ns/1ns
// =====================================================================
// Bench top
module bidirectional_port_pins_bench;
  import gpio_port_pkg::*;
  // Stimulus and observed signals
  logic         clk = 0, rst_n = 0, wr_en = 0, wr_dir = 0, rd_en = 0;
  port_sel_t    port_sel = '0;
  port_word_t   wr_data = '0, rd_data, rd_dir, d, r;
  logic         rd_valid;
  logic [103:0] pin_in, pin_out, pin_oe_n, ext_val = '0, ext_en = '0;
  int           error_cnt = 0, n_checks = 0;
  // 100 ns clock
  always #50 clk = ~clk;
  bidirectional_port_pins DUT (.clk(clk), .rst_n(rst_n), .wr_en(wr_en), .wr_dir(wr_dir),
    .port_sel(port_sel), .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data),
    .rd_dir(rd_dir), .rd_valid(rd_valid), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n));
  pin_load_model LOAD (.clk(clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
  // =====================================================================
  // Shared tasks
  task chk(input port_word_t got, input port_word_t exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One write pulse, then time for the pins to follow
  task wr(input int p, input logic dir, input port_word_t v);
    @(posedge clk);
    port_sel <= p[3:0];
    wr_dir   <= dir;
    wr_data  <= v;
    wr_en    <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // One read pulse; bounded wait for the answer
  task rd(input int p);
    int k;
    @(posedge clk);
    port_sel <= p[3:0];
    rd_en    <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    for (k = 0; k < 8; k++) begin
      @(posedge clk);
      #1;
      if (rd_valid === 1'b1) break;
    end
    if (k == 8) begin
      // Answer never came: count it and close the run
      error_cnt++;
      end_sim;
    end else begin
      d = rd_data;
      r = rd_dir;
    end
  endtask
  // =====================================================================
  // Scenarios
  // Every port floats after reset
  task t_reset;
    for (int p = 0; p < 13; p++) begin
      chk(pin_oe_n[p*8+:8], 8'hFF);
      chk(pin_out[p*8+:8], 8'h00);
      rd(p);
      chk(r, 8'h00);
    end
  endtask
  // Distinct direction pattern per port, whole byte checked at the enables and in readback
  task t_dir_bits;
    port_word_t v;
    for (int p = 0; p < 13; p++) begin
      v = 8'(p) * 8'h13 + 8'h01;
      wr(p, 1'b1, v);
      chk(pin_oe_n[p*8+:8], ~v);
      rd(p);
      chk(r, v);
    end
  endtask
  // Latch written while floating; pin level read back
  task t_input;
    wr(3, 1'b1, 8'h00);
    @(posedge clk);
    ext_en[31:24]  <= 8'hFF;
    ext_val[31:24] <= 8'hA5;
    wr(3, 1'b0, 8'h3C);
    repeat (4) @(posedge clk);
    chk(pin_oe_n[31:24], 8'hFF);
    chk(pin_out[31:24], 8'h00);
    rd(3);
    chk(d, 8'hA5);
  endtask
  // Output drives the stored latch; loaded pin does not corrupt readback
  task t_output;
    @(posedge clk);
    ext_val[31:24] <= 8'hC3;
    wr(3, 1'b1, 8'hFF);
    chk(pin_out[31:24], 8'h3C);
    chk(pin_oe_n[31:24], 8'h00);
    repeat (4) @(posedge clk);
    rd(3);
    chk(d, 8'h3C);
    // Mixed port: low nibble latch, high nibble pin level
    wr(3, 1'b1, 8'h0F);
    repeat (4) @(posedge clk);
    rd(3);
    chk(d, 8'hCC);
  endtask
  // Reset in mid-run floats every pin again; unmapped port is ignored
  task t_reset_mid;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 13; p++) begin
      chk(pin_oe_n[p*8+:8], 8'hFF);
    end
    rd(3);
    chk(r, 8'h00);
    chk(d, 8'hC3);
    wr(13, 1'b1, 8'hFF);
    for (int p = 0; p < 13; p++) begin
      chk(pin_oe_n[p*8+:8], 8'hFF);
    end
    rd(13);
    chk(r, 8'h00);
    chk(d, 8'h00);
  endtask
  // =====================================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_dir_bits;
    t_input;
    t_output;
    t_reset_mid;
    end_sim;
  end
endmodule // bidirectional_port_pins_bench
